// [inc/eic_if_defs.vh]
`ifndef EIC_IF_DEFS_VH
`define EIC_IF_DEFS_VH

// APB register byte addresses
`define ADDR_MODE_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_CAUSE 12'h008
`define ADDR_SHADOW 12'h00C
`define ADDR_EXC_BASE 12'h010
`define ADDR_VEC_OUT 12'h014
`define ADDR_SET_MAP 12'h018
`define ADDR_ACTION 12'h01C
`define ADDR_IDENT 12'h020

// Mode control fields
`define MC_PRESENT 0
`define MC_IVEN 1
`define MC_BOOT 2
`define MC_VS_LO 4
`define MC_VS_HI 8
`define MC_RESET 32'h0000_0005

// Status fields
`define ST_GIE 0
`define ST_EXL 1
`define ST_ERL 2
`define ST_LVL_LO 10
`define ST_LVL_HI 17
`define ST_SWM_LO 8
`define ST_SWM_HI 9
`define ST_RESET 32'h0000_0004

// Cause fields
`define CA_SW_LO 0
`define CA_SW_HI 1
`define CA_TIMER 30
`define CA_FDC 21
`define CA_LVL_LO 10
`define CA_LVL_HI 17

// Shadow control fields
`define SS_CUR_LO 0
`define SS_CUR_HI 3
`define SS_PREV_LO 6
`define SS_PREV_HI 9
`define SS_EIC_LO 18
`define SS_EIC_HI 21

// Action register: write 1 to leave exception level and restore shadow set
`define ACT_RETURN 0

// Vector offset arithmetic
`define VEC_BASE_OFFSET 18'h00200
`define VS_SHIFT 5
`define VEC_MAX_VI 6'h09

`endif

// [hw/eic_interrupt_interface.v]
// Function
// - Mode needs present, spacing, vectored, no boot
// - Drive software, timer, debug requests out
// - Level is 8-bit, zero means none
// - Eight individual interrupt lines, masked by status, highest pending wins
// - Build option: vector number or full offset
// - Never use level as vector number
// - Status mask bits hold current level
// - Take request above level when enabled
// - Latch level into cause, acknowledge controller
// - Latched level updates only on interrupt
// - Vector number not stored software-visibly
// - Controller supplies shadow set, map ignored
// - Latch shadow set with level, same cycle loaded as current set
// - Offset is 200h plus number times spacing
// - Vector range 0-9 vectored, 0-63 external
// - Spacing resets zero, zero means compatibility
// - Handler address is base OR offset
// - 64 vectors from 6-bit number input
// - Full offset option uses 17-bit input
// - Move current set to previous, load new
`timescale 1ns/100ps
`include "eic_if_defs.vh"

module eic_interrupt_interface #(
    parameter FULL_OFFSET = 0,
    parameter [31:0] IDENT_VALUE = 32'h0000_A5A5 // Arbitrary identity value
) (
    input wire i_clk, // Core clock
    input wire i_sys_rst, // Synchronous reset, active high
    input wire i_psel, // APB select
    input wire i_penable, // APB enable
    input wire i_pwrite, // APB write
    input wire [11:0] i_paddr, // APB byte address
    input wire [31:0] i_pwdata, // APB write data
    input wire [3:0] i_pstrb, // APB byte strobes
    output wire [31:0] o_prdata, // APB read data
    output wire o_pready, // APB ready
    output wire o_pslverr, // APB error
    input wire [7:0] i_requested_priority_level, // Encoded level from controller
    input wire [5:0] i_vector_number_in, // Vector number from controller
    input wire [17:1] i_vector_offset_in, // Full offset from controller
    input wire [3:0] i_controller_shadow_set, // Shadow set from controller
    input wire [7:0] i_hw_lines, // Individual lines in vectored mode
    input wire i_timer_irq, // Core timer request
    input wire i_fdc_irq, // Debug channel request
    output reg o_eic_ack, // Request taken, one cycle
    output reg o_irq_to_pipe, // Interrupt signalled to pipeline
    output reg [1:0] o_sw_irq, // Software requests to controller
    output reg o_timer_irq, // Timer request to controller
    output reg o_fdc_irq, // Debug channel request to controller
    output reg o_ext_mode, // External-controller mode active
    output reg [31:0] o_handler_addr // Handler address of last interrupt
);

    reg [31:0] mode_q;
    reg [31:0] status_q;
    reg [31:0] cause_q;
    reg [31:0] shadow_q;
    reg [31:0] exc_base_q;
    reg [31:0] set_map_q;
    reg [31:0] prdata_q;

    wire [4:0] vs = mode_q[`MC_VS_HI:`MC_VS_LO];
    wire [7:0] cur_level = status_q[`ST_LVL_HI:`ST_LVL_LO];
    wire ints_on = status_q[`ST_GIE] & ~status_q[`ST_EXL] & ~status_q[`ST_ERL];
    wire ext_mode = mode_q[`MC_PRESENT] & (vs != 5'h00) & mode_q[`MC_IVEN]
        & ~mode_q[`MC_BOOT];
    wire vi_mode = ~mode_q[`MC_PRESENT] & (vs != 5'h00) & mode_q[`MC_IVEN]
        & ~mode_q[`MC_BOOT];

    // Strict compare; level zero can never exceed any current level
    wire ext_take = ext_mode & ints_on
        & (i_requested_priority_level > cur_level);

    // Vectored mode: highest pending line wins, vector is line plus two
    wire [7:0] vi_pend = i_hw_lines & status_q[`ST_LVL_HI:`ST_LVL_LO];
    wire [1:0] sw_pend = cause_q[`CA_SW_HI:`CA_SW_LO] & status_q[`ST_SWM_HI:`ST_SWM_LO];
    wire vi_take = vi_mode & ints_on & ((vi_pend != 8'h00) | (sw_pend != 2'b00));
    wire take = ext_take | vi_take;

    function [5:0] prio_vec;
        input [7:0] hw;
        input [1:0] sw;
        integer k;
        begin
            prio_vec = sw[1] ? 6'h01 : 6'h00;
            for (k = 0; k < 8; k = k + 1)
            begin
                if (hw[k])
                    prio_vec = k[5:0] + 6'h02;
            end
        end
    endfunction

    // Vector never derived from the level itself
    wire [5:0] vi_vec = prio_vec(vi_pend, sw_pend);
    wire [5:0] vec_num = ext_mode ? i_vector_number_in : vi_vec;
    wire [17:0] num_off = {12'h000, vec_num} * {8'h00, vs, 5'b00000};
    wire [17:0] calc_off = `VEC_BASE_OFFSET + num_off;
    wire [17:0] sel_off = (FULL_OFFSET != 0 && ext_mode) ?
        {i_vector_offset_in, 1'b0} : calc_off;

    wire acc = i_psel & i_penable;
    wire wr = acc & i_pwrite;
    wire rd = acc & ~i_pwrite;
    wire ret_req = wr && (i_paddr == `ADDR_ACTION) && i_pwdata[`ACT_RETURN];

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1)
            begin
                if (strb[b])
                    merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `ADDR_MODE_CTRL) || (a == `ADDR_STATUS) ||
                (a == `ADDR_CAUSE) || (a == `ADDR_SHADOW) ||
                (a == `ADDR_EXC_BASE) || (a == `ADDR_VEC_OUT) ||
                (a == `ADDR_SET_MAP) || (a == `ADDR_ACTION) ||
                (a == `ADDR_IDENT);
        end
    endfunction

    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~mapped(i_paddr);
    assign o_prdata = prdata_q;

    reg [31:0] rd_mux;
    always @*
    begin
        case (i_paddr)
            `ADDR_MODE_CTRL: rd_mux = mode_q;
            `ADDR_STATUS: rd_mux = status_q;
            `ADDR_CAUSE: rd_mux = cause_q;
            `ADDR_SHADOW: rd_mux = shadow_q;
            `ADDR_EXC_BASE: rd_mux = exc_base_q;
            `ADDR_VEC_OUT: rd_mux = o_handler_addr;
            `ADDR_SET_MAP: rd_mux = set_map_q;
            `ADDR_IDENT: rd_mux = IDENT_VALUE;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is registered in the setup phase, so it is valid in the access phase; pready
    // stays high, thus a reading master samples o_prdata at the edge ending the access.
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
            prdata_q <= 32'h0000_0000;
        else if (i_psel & ~i_penable & ~i_pwrite)
            prdata_q <= rd_mux;
    end

    // Shadow set for the interrupt taken outside external mode
    wire [3:0] map_set = set_map_q[{vec_num[2:0], 2'b00} +: 4];

    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            mode_q <= `MC_RESET;
            status_q <= `ST_RESET;
            cause_q <= 32'h0000_0000;
            shadow_q <= 32'h0000_0000;
            exc_base_q <= 32'h0000_0000;
            set_map_q <= 32'h0000_0000;
            o_eic_ack <= 1'b0;
            o_irq_to_pipe <= 1'b0;
            o_handler_addr <= 32'h0000_0000;
        end
        else
        begin
            o_eic_ack <= 1'b0;
            o_irq_to_pipe <= 1'b0;
            if (wr && i_paddr == `ADDR_MODE_CTRL)
                mode_q <= merge(mode_q, i_pwdata, i_pstrb);
            if (wr && i_paddr == `ADDR_STATUS)
                status_q <= merge(status_q, i_pwdata, i_pstrb);
            if (wr && i_paddr == `ADDR_CAUSE)
                cause_q[`CA_SW_HI:`CA_SW_LO] <= i_pwdata[`CA_SW_HI:`CA_SW_LO];
            if (wr && i_paddr == `ADDR_SHADOW)
                shadow_q <= merge(shadow_q, i_pwdata, i_pstrb);
            if (wr && i_paddr == `ADDR_EXC_BASE)
                exc_base_q <= merge(exc_base_q, i_pwdata, i_pstrb);
            if (wr && i_paddr == `ADDR_SET_MAP)
                set_map_q <= merge(set_map_q, i_pwdata, i_pstrb);
            cause_q[`CA_TIMER] <= i_timer_irq;
            cause_q[`CA_FDC] <= i_fdc_irq;
            if (ret_req)
            begin
                status_q[`ST_EXL] <= 1'b0;
                shadow_q[`SS_CUR_HI:`SS_CUR_LO] <= shadow_q[`SS_PREV_HI:`SS_PREV_LO];
            end
            // Taking an interrupt wins over a same-cycle software write
            if (take)
            begin
                o_irq_to_pipe <= 1'b1;
                status_q[`ST_EXL] <= 1'b1;
                o_handler_addr <= exc_base_q | {14'h0000, sel_off};
                shadow_q[`SS_PREV_HI:`SS_PREV_LO] <= shadow_q[`SS_CUR_HI:`SS_CUR_LO];
                if (ext_mode)
                begin
                    o_eic_ack <= 1'b1;
                    cause_q[`CA_LVL_HI:`CA_LVL_LO] <= i_requested_priority_level;
                    shadow_q[`SS_EIC_HI:`SS_EIC_LO] <= i_controller_shadow_set;
                    shadow_q[`SS_CUR_HI:`SS_CUR_LO] <= i_controller_shadow_set;
                end
                else
                    shadow_q[`SS_CUR_HI:`SS_CUR_LO] <= map_set;
            end
        end
    end

    // Exported requests only meaningful to the controller in external mode
    always @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_sw_irq <= 2'b00;
            o_timer_irq <= 1'b0;
            o_fdc_irq <= 1'b0;
            o_ext_mode <= 1'b0;
        end
        else
        begin
            o_sw_irq <= ext_mode ? cause_q[`CA_SW_HI:`CA_SW_LO] : 2'b00;
            o_timer_irq <= ext_mode & i_timer_irq;
            o_fdc_irq <= ext_mode & i_fdc_irq;
            o_ext_mode <= ext_mode;
        end
    end

endmodule

// [testbench/eic_if_asserts.sv]
`timescale 1ns/100ps
module eic_if_asserts (
    input wire i_clk, // Clock
    input wire i_sys_rst, // Reset
    input wire [7:0] i_requested_priority_level, // Level
    input wire i_timer_irq, // Timer in
    input wire o_eic_ack, // Ack
    input wire o_irq_to_pipe, // Take
    input wire [1:0] o_sw_irq, // Sw out
    input wire o_timer_irq, // Timer out
    input wire o_fdc_irq, // Debug out
    input wire o_ext_mode, // Mode
    input wire [31:0] o_handler_addr // Handler
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ack_gap_a: assert property (o_eic_ack |=> !o_eic_ack [*2])
        else $error("ack repeated");
    zero_level_a: assert property (i_requested_priority_level == 8'h00 |=> !o_eic_ack)
        else $error("ack for zero level");
    ack_level_a: assert property (o_eic_ack |-> $past(i_requested_priority_level) != 8'h00)
        else $error("ack without level");
    ack_pipe_a: assert property (o_eic_ack |-> o_irq_to_pipe)
        else $error("ack without take");
    ack_mode_a: assert property (o_eic_ack |-> o_ext_mode)
        else $error("ack outside mode");
    fwd_off_a: assert property (!o_ext_mode |-> {o_sw_irq, o_timer_irq, o_fdc_irq} == 4'h0)
        else $error("forwarded outside mode");
    timer_fwd_a: assert property (o_ext_mode |-> o_timer_irq == $past(i_timer_irq))
        else $error("timer not forwarded");
    addr_hold_a: assert property (!o_irq_to_pipe |-> $stable(o_handler_addr))
        else $error("handler moved");
    cover property (o_eic_ack);
    cover property ($rose(o_ext_mode));
    cover property (o_timer_irq);
endmodule
bind eic_interrupt_interface eic_if_asserts chk (.i_clk, .i_sys_rst,
    .i_requested_priority_level, .i_timer_irq, .o_eic_ack, .o_irq_to_pipe,
    .o_sw_irq, .o_timer_irq, .o_fdc_irq, .o_ext_mode, .o_handler_addr);

// [testbench/eic_ctrl_model.sv]
`timescale 1ns/100ps
module eic_ctrl_model (
    input wire i_clk, // Clock
    input wire i_sys_rst, // Reset
    input wire i_start, // New request
    input wire [7:0] i_lvl, // Level
    input wire [5:0] i_vec, // Vector
    input wire [3:0] i_set, // Shadow set
    input wire i_ack, // Ack from core
    output logic [7:0] o_level = 8'h00, // Level out
    output logic [5:0] o_vec = 6'h00, // Vector out
    output logic [3:0] o_set = 4'h0 // Set out
);
    always @(posedge i_clk)
        if (i_sys_rst)
            o_level <= 8'h00;
        else if (i_start)
        begin
            // Held until the ack is seen
            o_level <= i_lvl;
            o_vec <= i_vec;
            o_set <= i_set;
        end
        else if (i_ack)
        begin
            // Level drops to zero; vector and set lines wander so stale values cannot pass
            o_level <= 8'h00;
            o_vec <= ~o_vec;
            o_set <= ~o_set;
        end
endmodule

// [testbench/tb_eic_interrupt_interface.sv]
`timescale 1ns/100ps
module tb_eic_interrupt_interface;
    logic i_clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, start = 0, tmr = 0, fdc = 0;
    logic [11:0] pa = 0;
    logic [31:0] pd = 0, q;
    logic perr_q = 0;
    wire perr;
    logic [7:0] lvl = 0;
    logic [5:0] vec = 0;
    logic [3:0] set = 0;
    wire [7:0] rl;
    wire [5:0] rv;
    wire [3:0] rs;
    wire [31:0] prdata, haddr;
    wire pready, ack, irq, tout, fout, ext;
    wire [1:0] sw;
    integer errors = 0, comparisons = 0;
    eic_interrupt_interface dut (.i_clk(i_clk), .i_sys_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .i_pstrb(4'hF),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_requested_priority_level(rl),
        .i_vector_number_in(rv), .i_vector_offset_in(17'h00000), .i_controller_shadow_set(rs),
        .i_hw_lines(8'h00), .i_timer_irq(tmr), .i_fdc_irq(fdc), .o_eic_ack(ack),
        .o_irq_to_pipe(irq), .o_sw_irq(sw), .o_timer_irq(tout), .o_fdc_irq(fout),
        .o_ext_mode(ext), .o_handler_addr(haddr));
    eic_ctrl_model ctl (.i_clk(i_clk), .i_sys_rst(rst), .i_start(start), .i_lvl(lvl),
        .i_vec(vec), .i_set(set), .i_ack(ack), .o_level(rl), .o_vec(rv), .o_set(rs));
    initial
        forever #50 i_clk = ~i_clk;
    task close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge i_clk);
        pen <= 1;
        @(posedge i_clk);
        while (pready !== 1'b1)
            @(posedge i_clk);
        q = prdata;
        perr_q = perr;
        psel <= 0;
        pen <= 0;
        @(posedge i_clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 0);
        chk("register", q, e);
    endtask
    task take(input logic [7:0] l, input logic [5:0] v, input logic [3:0] s,
              input logic a, input logic [31:0] h);
        start <= 1;
        lvl <= l;
        vec <= v;
        set <= s;
        @(posedge i_clk);
        start <= 0;
        // Registered outputs are judged mid-cycle, away from the edge that launches them
        @(negedge i_clk);
        for (int n = 0; n < 12 && ack !== 1'b1; n++)
            @(negedge i_clk);
        chk("ack", ack, a);
        chk("pipe", irq, a);
        if (a)
            chk("handler", haddr, h);
        @(posedge i_clk);
        start <= 1;
        lvl <= 0;
        @(posedge i_clk);
        start <= 0;
    endtask
    task reset_values();
        rd(12'h000, 32'h5);
        rd(12'h004, 32'h4);
        chk("mode", ext, 0);
        apb(0, 12'h024, 0);
        chk("pslverr", perr_q, 1);
        chk("unmapped", q, 0);
    endtask
    task mode_gate();
        logic [31:0] m [5] = '{32'h12, 32'h03, 32'h11, 32'h17, 32'h13};
        for (int i = 0; i < 5; i++)
        begin
            apb(1, 12'h000, m[i]);
            @(posedge i_clk);
            chk("mode", ext, i == 4);
        end
    endtask
    task forwarding();
        apb(1, 12'h008, 32'h3);
        tmr <= 1;
        fdc <= 1;
        repeat (2) @(posedge i_clk);
        chk("forward", {sw, tout, fout}, 4'hF);
        apb(1, 12'h008, 32'h0);
        tmr <= 0;
        fdc <= 0;
        repeat (2) @(posedge i_clk);
        chk("forward", {sw, tout, fout}, 4'h0);
    endtask
    task priority_takes();
        apb(1, 12'h004, 32'h1);
        take(8'h05, 6'h03, 4'h2, 1, 32'h260);
        rd(12'h008, 32'h1400);
        rd(12'h00C, 32'h0008_0002);
        apb(1, 12'h01C, 32'h1);
        apb(1, 12'h004, 32'h1401);
        take(8'h05, 6'h01, 4'h1, 0, 0);
        take(8'h06, 6'h3F, 4'h1, 1, 32'h9E0);
        apb(1, 12'h01C, 32'h1);
        apb(1, 12'h010, 32'h8000_0000);
        apb(1, 12'h000, 32'h103);
        apb(1, 12'h004, 32'h1);
        take(8'hFF, 6'h3F, 4'h0, 1, 32'h8000_8000);
    endtask
    initial
    begin
        // Whole run needs about a hundred cycles
        #500000;
        errors++;
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge i_clk);
        rst <= 0;
        reset_values();
        mode_gate();
        forwarding();
        priority_takes();
        close_out();
    end
endmodule
